/* File: verilog/rec_logger_pkg.sv */
// Purpose: constants shared by the measurement record logger
// Assumes: 40 MHz system clock, 16-bit raw samples, eight channels
// Notes: long counts are overridable parameters of the top module
package rec_logger_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int NUM_CH = 8;
    localparam int SAMPLE_W = 16;
    localparam int VALUE_W = 16;
    localparam int ACC_W = 32;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 20;
    // current variant: 8 samples per second
    localparam int SAMPLES_PER_SEC_I = 8;
    localparam int SAMPLE_CYC_I = CLK_HZ / SAMPLES_PER_SEC_I;
    // resistance variant: one sample per 2.5 s (2500 ms)
    localparam int SAMPLE_MS_RTD = 2500;
    localparam int SAMPLE_CYC_RTD = (CLK_HZ / 1000) * SAMPLE_MS_RTD;
    localparam int ONE_SEC_CYC = CLK_HZ;
    localparam int MENU_HOLD_MS = 2000;
    localparam int MENU_HOLD_CYC = (CLK_HZ / 1000) * MENU_HOLD_MS;
    localparam int IDENT_MS = 1000;
    localparam int IDENT_CYC = (CLK_HZ / 1000) * IDENT_MS;
    localparam logic [11:0] PERIOD_MIN_S = 12'h001;
    localparam logic [11:0] PERIOD_MAX_S = 12'hE10;
    localparam logic [ADDR_W-1:0] MEM_WORDS_DEF = 20'h10000;
    // register map, word index on the plain port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PERIOD = 4'h1;
    localparam logic [3:0] REG_AVG_SEL = 4'h2;
    localparam logic [3:0] REG_SPAN = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_WPTR = 4'h5;
    localparam logic [3:0] REG_REMAIN = 4'h6;
    localparam logic [3:0] REG_SCALE_LO = 4'h7;
    localparam logic [3:0] REG_SCALE_HI = 4'h8;
    localparam logic [3:0] REG_SCALE_CH = 4'h9;
    // control fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_WRAP = 1;
    localparam int CTRL_TRIG_EN = 2;
    localparam int CTRL_TRIG_LVL = 3;
    localparam int CTRL_RTD = 4;
    localparam int CTRL_CLR_MEM = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [11:0] PERIOD_RESET = 12'h001;
    // span codes per channel, two bits each
    localparam logic [1:0] SPAN_0_20 = 2'h0;
    localparam logic [1:0] SPAN_4_20 = 2'h1;
    // raw codes: full 22 mA = FFFF, 20 mA = E8BA, 4 mA = 2E8C
    localparam logic [SAMPLE_W-1:0] RAW_20MA = 16'hE8BA;
    localparam logic [SAMPLE_W-1:0] RAW_4MA = 16'h2E8C;
    typedef enum logic [2:0] {
        ST_IDENT = 3'b001,
        ST_MEASURE = 3'b010,
        ST_MENU = 3'b100
    } ui_state_e;
endpackage

/* File: verilog/rec_logger.sv */
// Purpose: samples channels, scales linearly, records periodic values to memory
// Assumes: front end converts one channel per request; memory takes a word per strobe
// Notes: register port is single cycle, read data one cycle after strobe
//
// Contract
// - sample 8/s, or every 2.5 s RTD
// - linear proportional scaling of raw values
// - configuration writes never stop recording
// - per-channel span 0-20/4-20 extendable to 22
// - bar to user range, graph to allowable
// - lower extension only for 4-20 spans
// - common record period, 1 s to 1 h
// - record instants follow real-time seconds tick
// - digital input state suspends recording
// - per-channel momentary or averaged choice
// - average of all samples in period
// - live display always momentary
// - record holds no value-type marker
// - stop-when-full ceases writes when full
// - wraparound restarts at address zero
// - report time remaining until memory full
// - memory-full warning under both policies
// - identification screen then measurement mode
// - menu only after two second hold
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module rec_logger #(
    parameter int SAMPLE_CYC_I = rec_logger_pkg::SAMPLE_CYC_I,
    parameter int SAMPLE_CYC_RTD = rec_logger_pkg::SAMPLE_CYC_RTD,
    parameter int ONE_SEC_CYC = rec_logger_pkg::ONE_SEC_CYC,
    parameter int MENU_HOLD_CYC = rec_logger_pkg::MENU_HOLD_CYC,
    parameter int IDENT_CYC = rec_logger_pkg::IDENT_CYC,
    parameter logic [19:0] MEM_WORDS = rec_logger_pkg::MEM_WORDS_DEF
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic sample_req_o,
    output logic [2:0] sample_ch_o,
    input wire logic sample_valid_i,
    input wire logic [15:0] sample_raw_i,
    input wire logic trig_input_i,
    input wire logic menu_escape_key_i,
    output logic [2:0] live_ch_o,
    output logic [15:0] live_value_o,
    output logic live_valid_o,
    output logic [15:0] bar_value_o,
    output logic [15:0] graph_value_o,
    output logic over_hi_o,
    output logic under_lo_o,
    output logic mem_wr_o,
    output logic [19:0] mem_addr_o,
    output logic [15:0] mem_data_o,
    output logic mem_full_o,
    output logic ident_screen_o,
    output logic menu_active_o,
    output logic short_press_o
);
    localparam int N = rec_logger_pkg::NUM_CH;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [11:0] period;
        logic [7:0] avg_sel;
        logic [15:0] span;
        logic [15:0] lower_ext;
        logic [31:0] rdata;
        logic [31:0] smp_cnt;
        logic [31:0] sec_cnt;
        logic [11:0] sec_in_period;
        logic [2:0] ch;
        logic busy;
        logic [N-1:0][31:0] acc;
        logic [N-1:0][15:0] nsmp;
        logic [N-1:0][15:0] last;
        logic [N-1:0] updated;
        logic rec_pend;
        logic [3:0] rec_idx;
        logic [19:0] wptr;
        logic full;
        rec_logger_pkg::ui_state_e ui;
        logic [31:0] ui_cnt;
        logic [31:0] hold_cnt;
        logic key_q;
        logic short_p;
        logic [2:0] live_ch;
        logic [15:0] live_val;
        logic live_v;
        logic [15:0] bar;
        logic [15:0] graph;
        logic hi;
        logic lo;
        logic mwr;
        logic [15:0] mdata;
        logic [19:0] maddr;
    } state_s;

    state_s s_q, s_d;

    // linear map into 0..FFFF user range, saturating outside
    function automatic logic [15:0] scale_to(input logic [15:0] raw,
                                             input logic [15:0] lo_raw,
                                             input logic [15:0] hi_raw);
        logic [31:0] num;
        logic [15:0] span_w;
        num = 32'h0;
        span_w = hi_raw - lo_raw;
        if (raw <= lo_raw) begin
            scale_to = 16'h0000;
        end else if (raw >= hi_raw) begin
            scale_to = 16'hFFFF;
        end else begin
            num = {16'h0000, raw - lo_raw} * 32'h0000_FFFF;
            scale_to = 16'((num) / {16'h0000, span_w});
        end
    endfunction

    logic [15:0] span_lo_raw, allow_lo_raw;
    logic [1:0] cur_span;
    logic trig_hold, rec_tick, sample_tick;
    logic [31:0] sample_cyc;
    logic [19:0] remain_words;

    always_comb begin
        cur_span = s_q.span[2*s_q.ch +: 2];
        // 4 mA offset only meaningful on 4-20 span; else zero floor
        span_lo_raw = (cur_span == rec_logger_pkg::SPAN_4_20) ? rec_logger_pkg::RAW_4MA
                                                              : 16'h0000;
        allow_lo_raw = (cur_span == rec_logger_pkg::SPAN_4_20) ?
                       (span_lo_raw - s_q.lower_ext) : 16'h0000;
        sample_cyc = s_q.ctrl[rec_logger_pkg::CTRL_RTD] ? 32'(SAMPLE_CYC_RTD)
                                                        : 32'(SAMPLE_CYC_I);
        trig_hold = s_q.ctrl[rec_logger_pkg::CTRL_TRIG_EN] &&
                    (trig_input_i == s_q.ctrl[rec_logger_pkg::CTRL_TRIG_LVL]);
        // a rate switch may leave the count past the new limit
        sample_tick = (s_q.smp_cnt >= sample_cyc - 32'd1);
        rec_tick = (s_q.sec_cnt == 32'(ONE_SEC_CYC) - 32'd1) &&
                   (s_q.sec_in_period >= s_q.period - 12'h001);
        remain_words = s_q.full ? 20'h00000 : (MEM_WORDS - s_q.wptr);
    end

    always_comb begin
        s_d = s_q;
        s_d.mwr = 1'b0;
        s_d.live_v = 1'b0;
        s_d.short_p = 1'b0;
        s_d.rdata = 32'h0;
        // register port; writes touch config only, except the clear-memory bit, which clears full, and resets wptr unless a record word is written that cycle
        if (reg_wr_i) begin
            case (reg_addr_i)
                rec_logger_pkg::REG_CTRL: s_d.ctrl = reg_wdata_i;
                rec_logger_pkg::REG_PERIOD: begin
                    if (reg_wdata_i[11:0] < rec_logger_pkg::PERIOD_MIN_S) begin
                        s_d.period = rec_logger_pkg::PERIOD_MIN_S;
                    end else if (reg_wdata_i[11:0] > rec_logger_pkg::PERIOD_MAX_S) begin
                        s_d.period = rec_logger_pkg::PERIOD_MAX_S;
                    end else begin
                        s_d.period = reg_wdata_i[11:0];
                    end
                end
                rec_logger_pkg::REG_AVG_SEL: s_d.avg_sel = reg_wdata_i[7:0];
                rec_logger_pkg::REG_SPAN: s_d.span = reg_wdata_i[15:0];
                rec_logger_pkg::REG_SCALE_LO: begin
                    // extension capped at 4 mA floor so span never passes 0-22 mA
                    s_d.lower_ext = (reg_wdata_i[15:0] > rec_logger_pkg::RAW_4MA) ?
                                    rec_logger_pkg::RAW_4MA : reg_wdata_i[15:0];
                end
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                rec_logger_pkg::REG_CTRL: s_d.rdata = s_q.ctrl;
                rec_logger_pkg::REG_PERIOD: s_d.rdata = {20'h00000, s_q.period};
                rec_logger_pkg::REG_AVG_SEL: s_d.rdata = {24'h000000, s_q.avg_sel};
                rec_logger_pkg::REG_SPAN: s_d.rdata = {16'h0000, s_q.span};
                rec_logger_pkg::REG_STATUS: s_d.rdata = {27'h0, s_q.ui, trig_hold, s_q.full};
                rec_logger_pkg::REG_WPTR: s_d.rdata = {12'h000, s_q.wptr};
                // remaining seconds = words left / channels * period
                rec_logger_pkg::REG_REMAIN:
                    s_d.rdata = 32'({12'h000, remain_words} / N) * {20'h0, s_q.period};
                rec_logger_pkg::REG_SCALE_LO: s_d.rdata = {16'h0000, s_q.lower_ext};
                default: s_d.rdata = 32'h0;
            endcase
        end
        if (reg_wr_i && reg_addr_i == rec_logger_pkg::REG_CTRL &&
            reg_wdata_i[rec_logger_pkg::CTRL_CLR_MEM]) begin
            s_d.wptr = 20'h00000;
            s_d.full = 1'b0;
            s_d.ctrl[rec_logger_pkg::CTRL_CLR_MEM] = 1'b0;
        end

        // sampling timebase
        s_d.smp_cnt = sample_tick ? 32'h0 : s_q.smp_cnt + 32'd1;
        if (sample_tick && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.ch = 3'h0;
        end
        if (s_q.busy && sample_valid_i) begin
            s_d.last[s_q.ch] = sample_raw_i;
            s_d.acc[s_q.ch] = s_q.acc[s_q.ch] + {16'h0000, sample_raw_i};
            s_d.nsmp[s_q.ch] = s_q.nsmp[s_q.ch] + 16'h0001;
            s_d.updated[s_q.ch] = 1'b1;
            // live path always takes the momentary sample
            s_d.live_ch = s_q.ch;
            s_d.live_val = sample_raw_i;
            s_d.live_v = 1'b1;
            s_d.bar = scale_to(sample_raw_i, span_lo_raw, rec_logger_pkg::RAW_20MA);
            s_d.graph = scale_to(sample_raw_i, allow_lo_raw, 16'hFFFF);
            s_d.hi = (sample_raw_i == 16'hFFFF);
            s_d.lo = (sample_raw_i < allow_lo_raw);
            if (s_q.ch == 3'(N - 1)) begin
                s_d.busy = 1'b0;
            end else begin
                s_d.ch = s_q.ch + 3'h1;
            end
        end

        // real-time seconds and record instants
        s_d.sec_cnt = (s_q.sec_cnt == 32'(ONE_SEC_CYC) - 32'd1) ? 32'h0 : s_q.sec_cnt + 32'd1;
        if (s_q.sec_cnt == 32'(ONE_SEC_CYC) - 32'd1) begin
            s_d.sec_in_period = rec_tick ? 12'h000 : s_q.sec_in_period + 12'h001;
        end
        if (rec_tick && s_q.ctrl[rec_logger_pkg::CTRL_ENABLE] && !trig_hold &&
            !s_q.rec_pend) begin
            s_d.rec_pend = 1'b1;
            s_d.rec_idx = 4'h0;
        end
        if (s_q.rec_pend) begin
            if (s_q.rec_idx == 4'(N)) begin
                s_d.rec_pend = 1'b0;
            end else begin
                if (!s_q.full || s_q.ctrl[rec_logger_pkg::CTRL_WRAP]) begin
                    s_d.mwr = 1'b1;
                    s_d.maddr = s_q.wptr;
                    // stored word is value only, no mode tag
                    s_d.mdata = (s_q.avg_sel[s_q.rec_idx[2:0]] &&
                                 s_q.nsmp[s_q.rec_idx[2:0]] != 16'h0000) ?
                                16'(s_q.acc[s_q.rec_idx[2:0]] /
                                    {16'h0000, s_q.nsmp[s_q.rec_idx[2:0]]}) :
                                s_q.last[s_q.rec_idx[2:0]];
                    if (s_q.wptr == MEM_WORDS - 20'h00001) begin
                        s_d.wptr = 20'h00000;
                        s_d.full = 1'b1;
                    end else begin
                        s_d.wptr = s_q.wptr + 20'h00001;
                    end
                end
                // a sample landing on its own clear cycle opens the new period
                if (s_q.busy && sample_valid_i && s_q.ch == s_q.rec_idx[2:0]) begin
                    s_d.acc[s_q.rec_idx[2:0]] = {16'h0000, sample_raw_i};
                    s_d.nsmp[s_q.rec_idx[2:0]] = 16'h0001;
                end else begin
                    s_d.acc[s_q.rec_idx[2:0]] = 32'h0;
                    s_d.nsmp[s_q.rec_idx[2:0]] = 16'h0000;
                end
                s_d.rec_idx = s_q.rec_idx + 4'h1;
            end
        end

        // power-up screen, menu key hold
        s_d.key_q = menu_escape_key_i;
        case (s_q.ui)
            rec_logger_pkg::ST_IDENT: begin
                s_d.ui_cnt = s_q.ui_cnt + 32'd1;
                if (s_q.ui_cnt == 32'(IDENT_CYC) - 32'd1) begin
                    s_d.ui = rec_logger_pkg::ST_MEASURE;
                end
            end
            rec_logger_pkg::ST_MEASURE: begin
                if (menu_escape_key_i) begin
                    s_d.hold_cnt = s_q.hold_cnt + 32'd1;
                    if (s_q.hold_cnt == 32'(MENU_HOLD_CYC) - 32'd1) begin
                        s_d.ui = rec_logger_pkg::ST_MENU;
                    end
                end else begin
                    s_d.hold_cnt = 32'h0;
                    s_d.short_p = s_q.key_q && (s_q.hold_cnt < 32'(MENU_HOLD_CYC));
                end
            end
            rec_logger_pkg::ST_MENU: begin
                s_d.hold_cnt = 32'h0;
                if (menu_escape_key_i && !s_q.key_q) begin
                    s_d.ui = rec_logger_pkg::ST_MEASURE;
                end
            end
            default: s_d.ui = rec_logger_pkg::ST_IDENT;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.ctrl <= rec_logger_pkg::CTRL_RESET;
            s_q.period <= rec_logger_pkg::PERIOD_RESET;
            s_q.ui <= rec_logger_pkg::ST_IDENT;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    assign sample_req_o = s_q.busy;
    assign sample_ch_o = s_q.ch;
    assign live_ch_o = s_q.live_ch;
    assign live_value_o = s_q.live_val;
    assign live_valid_o = s_q.live_v;
    assign bar_value_o = s_q.bar;
    assign graph_value_o = s_q.graph;
    assign over_hi_o = s_q.hi;
    assign under_lo_o = s_q.lo;
    assign mem_wr_o = s_q.mwr;
    assign mem_addr_o = s_q.maddr;
    assign mem_data_o = s_q.mdata;
    assign mem_full_o = s_q.full;
    assign ident_screen_o = (s_q.ui == rec_logger_pkg::ST_IDENT);
    assign menu_active_o = (s_q.ui == rec_logger_pkg::ST_MENU);
    assign short_press_o = s_q.short_p;

    property p_stop_full;
        @(posedge clk_sys_i) disable iff (reset_i)
        (s_q.full && !s_q.ctrl[rec_logger_pkg::CTRL_WRAP] && !reg_wr_i) |=> !mem_wr_o;
    endproperty
    a_stop_full: assert property (p_stop_full) else $error("write after full");

    property p_wrap;
        @(posedge clk_sys_i) disable iff (reset_i)
        (mem_wr_o && mem_addr_o == MEM_WORDS - 20'h00001 && !reg_wr_i) |-> s_q.wptr == 20'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

    property p_full_flag;
        @(posedge clk_sys_i) disable iff (reset_i)
        (mem_wr_o && mem_addr_o == MEM_WORDS - 20'h00001) |-> mem_full_o;
    endproperty
    a_full_flag: assert property (p_full_flag) else $error("full not raised");

    property p_trig;
        @(posedge clk_sys_i) disable iff (reset_i)
        (rec_tick && trig_hold && !s_q.rec_pend) |=> !s_q.rec_pend;
    endproperty
    a_trig: assert property (p_trig) else $error("record while suspended");

    property p_menu;
        @(posedge clk_sys_i) disable iff (reset_i)
        ($rose(menu_active_o)) |-> s_q.key_q && $past(s_q.hold_cnt) ==
                                   32'(MENU_HOLD_CYC) - 32'd1;
    endproperty
    a_menu: assert property (p_menu) else $error("menu entered early");

    property p_ident;
        @(posedge clk_sys_i) disable iff (reset_i)
        $fell(ident_screen_o) |-> $past(s_q.ui_cnt) == 32'(IDENT_CYC) - 32'd1;
    endproperty
    a_ident: assert property (p_ident) else $error("ident left early");

    property p_live;
        @(posedge clk_sys_i) disable iff (reset_i)
        (s_q.busy && sample_valid_i) |=> live_valid_o && live_value_o == $past(sample_raw_i);
    endproperty
    a_live: assert property (p_live) else $error("live not momentary");

    property p_clear;
        @(posedge clk_sys_i) disable iff (reset_i)
        (s_q.rec_pend && s_q.rec_idx == 4'h0 && !(s_q.busy && sample_valid_i && s_q.ch == 3'h0))
        |=> s_q.nsmp[0] == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("accumulator not cleared");
endmodule
`default_nettype wire

/* File: bench/rec_logger_fe_model.sv */
// Purpose: front end and record memory seen from the logger's far side
// Assumes: one conversion answered per request, memory takes one word per strobe
// Notes: raw bus toggles between the last answer and its inverse every cycle between conversions
`timescale 1ns/100ps
`default_nettype none
module rec_logger_fe_model (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic sample_req_i,
    input wire logic [2:0] sample_ch_i,
    input wire logic [3:0] lat_i,
    input wire logic [15:0] base_i,
    input wire logic step_i,
    input wire logic mem_wr_i,
    input wire logic [19:0] mem_addr_i,
    input wire logic [15:0] mem_data_i,
    output logic sample_valid_o,
    output logic [15:0] sample_raw_o,
    output int wr_count_o,
    output logic wrap_seen_o
);
    logic [15:0] mem [0:31];
    logic [3:0] wait_q;
    logic done_q;
    logic [2:0] done_ch_q;
    logic [11:0] round_q;
    logic [19:0] last_addr_q;
    always @(posedge clk_sys_i) begin
        sample_valid_o <= 1'b0;
        // a released bus never holds its last value
        sample_raw_o <= ~sample_raw_o;
        if (reset_i) begin
            wait_q <= 4'h0;
            done_q <= 1'b0;
            round_q <= 12'h000;
            wr_count_o <= 0;
            wrap_seen_o <= 1'b0;
            sample_raw_o <= 16'h0000;
        end else begin
            if (done_q && (!sample_req_i || sample_ch_i != done_ch_q)) begin
                done_q <= 1'b0;
            end
            if (sample_req_i && !done_q && !sample_valid_o) begin
                if (wait_q == lat_i) begin
                    sample_valid_o <= 1'b1;
                    sample_raw_o <= base_i + {5'h00, sample_ch_i, 8'h00}
                        + (step_i ? {2'b00, round_q, 2'b00} : 16'h0000);
                    wait_q <= 4'h0;
                    done_q <= 1'b1;
                    done_ch_q <= sample_ch_i;
                    if (sample_ch_i == 3'h7) begin
                        round_q <= round_q + 12'h001;
                    end
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
            if (mem_wr_i) begin
                mem[mem_addr_i[4:0]] <= mem_data_i;
                wr_count_o <= wr_count_o + 1;
                last_addr_q <= mem_addr_i;
                if (mem_addr_i == 20'h00000 && last_addr_q == 20'h0001F) begin
                    wrap_seen_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/rec_logger_tb.sv */
// Purpose: self-checking bench of the record logger with shortened counts
// Assumes: one second is 80 cycles, two sample rounds per second
// Notes: record words read back from the partner memory
`timescale 1ns/100ps
`default_nettype none
module rec_logger_tb;
    localparam int SEC = 80;
    typedef struct packed {logic [3:0] a; logic [31:0] e;} row_s;
    row_s rows [7] = '{'{4'h0, 32'h1}, '{4'h1, 32'h1}, '{4'h2, 32'h0}, '{4'h3, 32'h0},
        '{4'h6, 32'h4}, '{4'hF, 32'h0}, '{4'h4, 32'h8}};
    logic clk_sys_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, sample_valid_i;
    logic [3:0] reg_addr_i = 4'h0, lat = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
    logic sample_req_o, trig_input_i = 0, menu_escape_key_i = 0, live_valid_o, over_hi_o;
    logic [2:0] sample_ch_o, live_ch_o;
    logic [15:0] sample_raw_i, live_value_o, bar_value_o, graph_value_o, mem_data_o;
    logic [15:0] base = 16'h1000, w0, w1, lv [8], lb [8], lg [8];
    logic under_lo_o, mem_wr_o, mem_full_o, ident_screen_o, menu_active_o, short_press_o;
    logic step = 1, wrap_seen, ll [8], lh [8], req_d = 0, sp_seen = 0;
    logic [19:0] mem_addr_o;
    int fails = 0, tests_run = 0, wr_count, cyc_n = 0, rise = 0, ival = 0, c;
    always #12.5 clk_sys_i = ~clk_sys_i;
    rec_logger #(.SAMPLE_CYC_I(40), .SAMPLE_CYC_RTD(100), .ONE_SEC_CYC(SEC),
        .MENU_HOLD_CYC(32), .IDENT_CYC(8), .MEM_WORDS(20'h00020)) DUT (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sample_req_o(sample_req_o), .sample_ch_o(sample_ch_o),
        .sample_valid_i(sample_valid_i), .sample_raw_i(sample_raw_i),
        .trig_input_i(trig_input_i), .menu_escape_key_i(menu_escape_key_i),
        .live_ch_o(live_ch_o), .live_value_o(live_value_o), .live_valid_o(live_valid_o),
        .bar_value_o(bar_value_o), .graph_value_o(graph_value_o), .over_hi_o(over_hi_o),
        .under_lo_o(under_lo_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
        .mem_data_o(mem_data_o), .mem_full_o(mem_full_o), .ident_screen_o(ident_screen_o),
        .menu_active_o(menu_active_o), .short_press_o(short_press_o));
    rec_logger_fe_model fe (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .sample_req_i(sample_req_o), .sample_ch_i(sample_ch_o), .lat_i(lat), .base_i(base),
        .step_i(step), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
        .mem_data_i(mem_data_o), .sample_valid_o(sample_valid_i),
        .sample_raw_o(sample_raw_i), .wr_count_o(wr_count), .wrap_seen_o(wrap_seen));
    always @(posedge clk_sys_i) begin
        cyc_n <= cyc_n + 1;
        req_d <= sample_req_o;
        if (sample_req_o && !req_d) begin
            ival <= cyc_n - rise;
            rise <= cyc_n;
        end
        if (short_press_o) sp_seen <= 1'b1;
        if (live_valid_o) begin
            lv[live_ch_o] <= live_value_o;
            lb[live_ch_o] <= bar_value_o;
            lg[live_ch_o] <= graph_value_o;
            ll[live_ch_o] <= under_lo_o;
            lh[live_ch_o] <= over_hi_o;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    // waits for one full record of eight words, bounded by six seconds
    task automatic wait_rec();
        int n;
        n = wr_count + 8;
        c = 0;
        while (wr_count < n && c < 3 * 2 * SEC) begin
            cyc(1);
            c++;
        end
        chk(wr_count >= n, 1);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #(25 * 40000);
        fails++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        cyc(1);
        chk(ident_screen_o, 1);
        foreach (rows[i]) begin
            rd(rows[i].a, d);
            chk(d, rows[i].e);
        end
        chk(ident_screen_o, 0);
        wr(4'h0, 32'h23);
        wr(4'h2, 32'h01);
        wait_rec();
        wait_rec();
        w0 = fe.mem[fe.last_addr_q[4:0] - 5'h7];
        w1 = fe.mem[fe.last_addr_q[4:0] - 5'h6];
        wait_rec();
        chk(fe.mem[fe.last_addr_q[4:0] - 5'h7] & 16'h0003, 2);
        chk(fe.mem[fe.last_addr_q[4:0] - 5'h7] - w0, 8);
        chk(fe.mem[fe.last_addr_q[4:0] - 5'h6] - w1, 8);
        wr(4'h1, 32'h2);
        wait_rec();
        w1 = fe.mem[fe.last_addr_q[4:0] - 5'h6];
        wait_rec();
        chk(fe.mem[fe.last_addr_q[4:0] - 5'h6] - w1, 16);
        chk({wrap_seen, mem_full_o}, 2'b11);
        wr(4'h0, 32'h21);
        rd(4'h6, d);
        chk(d, 8);
        wr(4'h1, 32'h1);
        repeat (4) wait_rec();
        cyc(2);
        chk(mem_full_o, 1);
        c = wr_count;
        cyc(3 * SEC);
        chk(wr_count, c);
        wr(4'h0, 32'h2D);
        trig_input_i <= 1'b1;
        c = wr_count;
        cyc(3 * SEC);
        chk(wr_count, c);
        rd(4'h4, d);
        chk(d[1], 1);
        @(posedge clk_sys_i);
        trig_input_i <= 1'b0;
        wait_rec();
        @(posedge clk_sys_i);
        step <= 1'b0;
        base <= 16'h0000;
        wr(4'h2, 32'hFF);
        wr(4'h3, 32'h4);
        // partial extension: a full one would move the 4-20 floor to zero
        wr(4'h7, 32'h2000);
        cyc(90);
        chk({ll[1], ll[0]}, 2'b10);
        chk(lb[0], 16'h0000);
        @(posedge clk_sys_i);
        base <= 16'hE8BA;
        cyc(90);
        chk(lb[0], 16'hFFFF);
        chk(lg[0], 16'hE8BA);
        chk(lv[0], 16'hE8BA);
        chk(lv[3], 16'hEBBA);
        @(posedge clk_sys_i);
        base <= 16'hFFFF;
        cyc(90);
        chk(lg[0], 16'hFFFF);
        chk({lh[1], lh[0]}, 2'b01);
        @(posedge clk_sys_i);
        lat <= 4'h5;
        wr(4'h0, 32'h11);
        cyc(310);
        chk(ival, 100);
        @(posedge clk_sys_i);
        lat <= 4'h0;
        wr(4'h0, 32'h01);
        cyc(170);
        chk(ival, 40);
        @(posedge clk_sys_i);
        menu_escape_key_i <= 1'b1;
        cyc(28);
        @(posedge clk_sys_i);
        menu_escape_key_i <= 1'b0;
        cyc(4);
        chk({sp_seen, menu_active_o}, 2'b10);
        @(posedge clk_sys_i);
        menu_escape_key_i <= 1'b1;
        cyc(30);
        chk(menu_active_o, 0);
        cyc(6);
        chk(menu_active_o, 1);
        stop_test();
    end
endmodule
`default_nettype wire
